// ### design/mpwm_top.sv
// Purpose: Motor PWM configuration, reload buffering and fault masking
// Assumes: APB slave, one aligned word per 8-bit register
// Notes:   Byte address is four times the register index
//
// Overview of operation
// - Reload rate applied at period end
// - Reload rate reads holding value
// - Reload every 1, 2, 4, 8 periods
// - Independent bit picks pairs or channels
// - Polarity bits invert pairs 2, 1, 0
// - Prescaler divides by 1, 2, 4, 8
// - Prescaler buffered until reload, reads holding
// - Dead band keeps pair off at edges
// - No pulse shorter than least pulse
// - Debug entry faults unless masked
// - Aux fault faults unless masked
// - Comparator faults unless masked
// - Fault pin faults unless masked
// - Disabled: counter stopped, outputs off
// - Ready copies holding to working at reload
`timescale 1ns/1ns
`default_nettype none
module mpwm_top
    import mpwm_pkg::*;
#(
    parameter int NPAIR = 3 // Output pairs
) (
    input wire logic clk,                  // System clock, 250 MHz
    input wire logic resetn,               // Async reset, active low
    input wire logic [15:0] paddr,         // APB address
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB enable
    input wire logic pwrite,               // APB direction
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error, unmapped
    input wire logic debug_mode,           // CPU in debug
    input wire logic aux_fault,            // Fault 1 source
    input wire logic comparator_out,       // Comparator output
    input wire logic fault_pin,            // Fault 0 pin
    input wire logic external_count_clock, // External count clock
    output logic [NPAIR-1:0] pwm_out_h,    // High side outputs
    output logic [NPAIR-1:0] pwm_out_l,    // Low side outputs
    output logic irq                       // Interrupt, level
);
    // =========================================================
    // Register state
    logic [7:0] pwm_control_first;
    logic [7:0] pwm_control_second;
    logic [7:0] dead_band_count;
    logic [7:0] min_pulse_filter;
    logic [7:0] fault_source_mask;
    logic [7:0] hold_period;
    logic [7:0] hold_duty [2*NPAIR];
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] next_control_first;
    logic [7:0] next_control_second;
    logic [7:0] next_dead_band;
    logic [7:0] next_min_pulse;
    logic [7:0] next_fault_mask;
    logic [7:0] next_hold_period;
    logic [7:0] next_hold_duty [2*NPAIR];
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask;
    logic next_irq;

    // =========================================================
    // Bus state
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [11:0] idx;
    logic hit;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    // =========================================================
    // Modulator state
    logic [7:0] count;
    logic [2:0] per_cnt;
    logic [1:0] work_rate;
    logic [1:0] work_div;
    logic [7:0] work_period;
    logic [7:0] work_duty [2*NPAIR];
    logic fault_latch;
    logic [7:0] next_count;
    logic [2:0] next_per_cnt;
    logic [1:0] next_work_rate;
    logic [1:0] next_work_div;
    logic [7:0] next_work_period;
    logic [7:0] next_work_duty [2*NPAIR];
    logic next_fault_latch;
    logic tick;
    logic enabled;
    logic period_end;
    logic reload;
    logic [2:0] reload_lim;
    logic [3:0] fault_src;
    logic fault_any;
    logic run;

    assign enabled = pwm_control_first[EN_BIT];
    assign idx = paddr[13:2];
    assign wr_en = psel && penable && pready && pwrite && hit;
    assign wbyte = pwdata[7:0];

    // =========================================================
    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        rbyte = 8'h00;
        if (paddr[15:14] != 2'h0 || paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (idx == CTL0_IDX) begin
            rbyte = pwm_control_first;
        end else if (idx == CTL1_IDX) begin
            rbyte = pwm_control_second;
        end else if (idx == DB_IDX) begin
            rbyte = dead_band_count;
        end else if (idx == MPF_IDX) begin
            rbyte = min_pulse_filter;
        end else if (idx == FM_IDX) begin
            rbyte = fault_source_mask;
        end else if (idx == PER_IDX) begin
            rbyte = hold_period;
        end else if (idx >= DUTY0_IDX && idx < 12'(DUTY0_IDX + 2 * NPAIR)) begin
            rbyte = hold_duty[3'(idx - DUTY0_IDX)];
        end else if (idx == IRQ_STAT_IDX) begin
            rbyte = {6'h00, irq_status};
        end else if (idx == IRQ_MASK_IDX) begin
            rbyte = {6'h00, irq_mask};
        end else begin
            hit = 1'b0;
        end
    end

    // Bus answer, one access cycle
    always_comb begin
        next_pready = psel && !penable;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (psel && !penable) begin
            next_prdata = {24'h000000, rbyte};
            next_pslverr = !hit;
        end
    end

    // =========================================================
    // Period counter and reload events
    always_comb begin
        period_end = enabled && tick && count == work_period;
        case (work_rate)
            2'b00: reload_lim = 3'h0;
            2'b01: reload_lim = 3'h1;
            2'b10: reload_lim = 3'h3;
            default: reload_lim = 3'h7;
        endcase
        reload = period_end && per_cnt == reload_lim;
        next_count = count;
        next_per_cnt = per_cnt;
        if (!enabled) begin
            next_count = 8'h00;
            next_per_cnt = 3'h0;
        end else if (tick) begin
            next_count = period_end ? 8'h00 : 8'(count + 8'h01);
            if (period_end) begin
                next_per_cnt = reload ? 3'h0 : 3'(per_cnt + 3'h1);
            end
        end
        next_work_rate = work_rate;
        // Rate takes effect at period end
        if (period_end) begin
            next_work_rate = pwm_control_second[RLF_LSB+:2];
        end
        next_work_div = work_div;
        next_work_period = work_period;
        next_work_duty = work_duty;
        if (reload && pwm_control_first[READY_BIT]) begin
            next_work_div = pwm_control_second[CLOCK_DIVIDER_SEL_LSB+:2];
            next_work_period = hold_period;
            next_work_duty = hold_duty;
        end
    end

    // =========================================================
    // Fault sources and latch
    always_comb begin
        fault_src[3] = debug_mode && !fault_source_mask[FM_DBG_BIT];
        fault_src[2] = aux_fault && !fault_source_mask[FM_AUX_BIT];
        fault_src[1] = comparator_out && !fault_source_mask[FM_CMP_BIT];
        fault_src[0] = fault_pin && !fault_source_mask[FM_PIN_BIT];
        fault_any = |fault_src;
        next_fault_latch = fault_latch;
        if (fault_any) begin
            next_fault_latch = 1'b1;
        end else if (period_end || !enabled) begin
            next_fault_latch = 1'b0;
        end
        run = enabled && !fault_latch && !fault_any;
    end

    // =========================================================
    // Register writes and interrupt flags
    always_comb begin
        next_control_first = pwm_control_first;
        next_control_second = pwm_control_second;
        next_dead_band = dead_band_count;
        next_min_pulse = min_pulse_filter;
        next_fault_mask = fault_source_mask;
        next_hold_period = hold_period;
        next_hold_duty = hold_duty;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        // Hardware clears ready once values are taken
        if (reload) begin
            next_control_first[READY_BIT] = 1'b0;
        end
        if (wr_en) begin
            if (idx == CTL0_IDX) begin
                next_control_first = wbyte & CTL0_WMASK;
            end else if (idx == CTL1_IDX) begin
                next_control_second = wbyte;
                if (enabled) begin
                    next_control_second[INDEP_BIT] = pwm_control_second[INDEP_BIT];
                end
            end else if (idx == PER_IDX) begin
                next_hold_period = wbyte;
            end else if (idx >= DUTY0_IDX && idx < 12'(DUTY0_IDX + 2 * NPAIR)) begin
                next_hold_duty[3'(idx - DUTY0_IDX)] = wbyte;
            end else if (idx == IRQ_STAT_IDX) begin
                next_irq_status = irq_status & ~wbyte[1:0];
            end else if (idx == IRQ_MASK_IDX) begin
                next_irq_mask = wbyte[1:0];
            end else if (!enabled) begin
                if (idx == DB_IDX) begin
                    next_dead_band = wbyte;
                end else if (idx == MPF_IDX) begin
                    next_min_pulse = wbyte;
                end else if (idx == FM_IDX) begin
                    next_fault_mask = wbyte & FM_WMASK;
                end
            end
        end
        // Hardware set wins over clear
        if (reload) begin
            next_irq_status[IRQ_RELOAD_BIT] = 1'b1;
        end
        if (fault_any && !fault_latch) begin
            next_irq_status[IRQ_FAULT_BIT] = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // =========================================================
    // Registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_control_first <= CTL0_RST;
            pwm_control_second <= CTL1_RST;
            dead_band_count <= DB_RST;
            min_pulse_filter <= MPF_RST;
            fault_source_mask <= FM_RST;
            hold_period <= PER_RST;
            irq_status <= IRQ_RST;
            irq_mask <= IRQ_RST;
            irq <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            count <= 8'h00;
            per_cnt <= 3'h0;
            work_rate <= CTL1_RST[RLF_LSB+:2];
            work_div <= CTL1_RST[CLOCK_DIVIDER_SEL_LSB+:2];
            work_period <= PER_RST;
            fault_latch <= 1'b0;
            for (int i = 0; i < 2 * NPAIR; i++) begin
                hold_duty[i] <= DUTY_RST;
                work_duty[i] <= DUTY_RST;
            end
        end else begin
            pwm_control_first <= next_control_first;
            pwm_control_second <= next_control_second;
            dead_band_count <= next_dead_band;
            min_pulse_filter <= next_min_pulse;
            fault_source_mask <= next_fault_mask;
            hold_period <= next_hold_period;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            count <= next_count;
            per_cnt <= next_per_cnt;
            work_rate <= next_work_rate;
            work_div <= next_work_div;
            work_period <= next_work_period;
            fault_latch <= next_fault_latch;
            hold_duty <= next_hold_duty;
            work_duty <= next_work_duty;
        end
    end

    // =========================================================
    // Prescaler
    // Input clock divided
    mpwm_prescale u_prescale (
        .clk(clk),
        .resetn(resetn),
        .run(enabled),
        .ext_sel(pwm_control_first[EXTCLK_BIT]),
        .ext_in(external_count_clock),
        .div_sel(work_div),
        .tick(tick)
    );

    // =========================================================
    // Output pairs
    for (genvar p = 0; p < NPAIR; p++) begin : g_pair
        mpwm_pair u_pair (
            .clk(clk),
            .resetn(resetn),
            .tick(tick),
            .run(run),
            .count(count),
            .duty_h(work_duty[2*p]),
            .duty_l(work_duty[2*p+1]),
            .dead_band(dead_band_count),
            .min_pulse(min_pulse_filter),
            .indep(pwm_control_second[INDEP_BIT]),
            .invert(pwm_control_second[INV_LSB+p]),
            .out_h(pwm_out_h[p]),
            .out_l(pwm_out_l[p])
        );
    end
endmodule
`default_nettype wire

// ### design/mpwm_pkg.sv
// Purpose: Shared constants of the motor PWM configuration block
// Assumes: Register index times four gives the APB byte address
// Notes:   Indices double as the printed register offsets
package mpwm_pkg;
    // =========================================================
    // Register indices
    localparam logic [11:0] CTL0_IDX = 12'hf20;
    localparam logic [11:0] CTL1_IDX = 12'hf21;
    localparam logic [11:0] DB_IDX = 12'hf22;
    localparam logic [11:0] MPF_IDX = 12'hf23;
    localparam logic [11:0] FM_IDX = 12'hf24;
    localparam logic [11:0] PER_IDX = 12'hf29;
    localparam logic [11:0] DUTY0_IDX = 12'hf2a;
    localparam logic [11:0] IRQ_STAT_IDX = 12'hf30;
    localparam logic [11:0] IRQ_MASK_IDX = 12'hf31;
    // =========================================================
    // Reset values
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] DB_RST = 8'h01;
    localparam logic [7:0] MPF_RST = 8'h00;
    localparam logic [7:0] FM_RST = 8'h00;
    localparam logic [7:0] PER_RST = 8'hff;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    // =========================================================
    // Field positions
    localparam int EN_BIT = 0;
    localparam int READY_BIT = 1;
    localparam int EXTCLK_BIT = 2;
    localparam int RLF_LSB = 6;
    localparam int INDEP_BIT = 5;
    localparam int INV_LSB = 2;
    localparam int CLOCK_DIVIDER_SEL_LSB = 0;
    localparam int FM_DBG_BIT = 5;
    localparam int FM_AUX_BIT = 2;
    localparam int FM_CMP_BIT = 1;
    localparam int FM_PIN_BIT = 0;
    localparam logic [7:0] FM_WMASK = 8'h27;
    localparam logic [7:0] CTL0_WMASK = 8'h07;
    localparam int IRQ_RELOAD_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
endpackage

// ### design/mpwm_prescale.sv
// Purpose: Count clock prescaler giving a one-cycle tick per PWM clock
// Assumes: External count clock is synchronous to clk
// Notes:   Division ratio is 1, 2, 4 or 8
`timescale 1ns/1ns
`default_nettype none
module mpwm_prescale (
    input wire logic clk,          // System clock
    input wire logic resetn,       // Async reset, active low
    input wire logic run,          // Counter running
    input wire logic ext_sel,      // Count the external clock
    input wire logic ext_in,       // External count clock
    input wire logic [1:0] div_sel, // Division code
    output logic tick              // One PWM clock tick
);
    logic ext_prev;
    logic [2:0] cnt;
    logic next_ext_prev;
    logic [2:0] next_cnt;
    logic next_tick;
    logic src;
    logic [2:0] lim;

    // Source select and divide
    always_comb begin
        next_ext_prev = ext_in;
        src = ext_sel ? (ext_in & ~ext_prev) : 1'b1;
        lim = 3'(({1'b0, 3'h1} << div_sel) - 4'h1);
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!run) begin
            next_cnt = 3'h0;
        end else if (src) begin
            if ((cnt & lim) == lim) begin
                next_tick = 1'b1;
            end
            next_cnt = 3'(cnt + 3'h1);
        end
    end

    // State registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_prev <= 1'b0;
            cnt <= 3'h0;
            tick <= 1'b0;
        end else begin
            ext_prev <= next_ext_prev;
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ### design/mpwm_pair.sv
// Purpose: One output pair with pulse filter, dead band and polarity
// Assumes: tick marks one prescaled PWM clock
// Notes:   Off-state is the inactive level after polarity
`timescale 1ns/1ns
`default_nettype none
module mpwm_pair (
    input wire logic clk,            // System clock
    input wire logic resetn,         // Async reset, active low
    input wire logic tick,           // PWM clock tick
    input wire logic run,            // Modulator drives pins
    input wire logic [7:0] count,    // Period counter
    input wire logic [7:0] duty_h,   // High side duty
    input wire logic [7:0] duty_l,   // Low side duty, independent mode
    input wire logic [7:0] dead_band, // Dead band in ticks
    input wire logic [7:0] min_pulse, // Least pulse in ticks
    input wire logic indep,          // Independent channels
    input wire logic invert,         // Pair polarity
    output logic out_h,              // High side pin
    output logic out_l               // Low side pin
);
    logic [1:0] filt;
    logic [7:0] age [2];
    logic [7:0] db_cnt;
    logic [1:0] next_filt;
    logic [7:0] next_age [2];
    logic [7:0] next_db_cnt;
    logic next_out_h;
    logic next_out_l;
    logic [1:0] raw;
    logic act_h;
    logic act_l;
    logic gap_clear;

    // Compare, filter, dead band
    always_comb begin
        raw[0] = count < duty_h;
        raw[1] = indep ? (count < duty_l) : ~raw[0];
        next_filt = filt;
        for (int i = 0; i < 2; i++) begin
            next_age[i] = age[i];
            if (tick) begin
                if (raw[i] != filt[i] && age[i] >= min_pulse) begin
                    next_filt[i] = raw[i];
                    next_age[i] = 8'h01;
                end else if (age[i] != 8'hff) begin
                    next_age[i] = 8'(age[i] + 8'h01);
                end
            end
        end
        next_db_cnt = db_cnt;
        if (!indep && next_filt[0] != filt[0]) begin
            next_db_cnt = dead_band;
        end else if (tick && db_cnt != 8'h00) begin
            next_db_cnt = 8'(db_cnt - 8'h01);
        end
        gap_clear = indep || db_cnt == 8'h00;
        act_h = filt[0] & gap_clear;
        act_l = (indep ? filt[1] : ~filt[0]) & gap_clear;
        next_out_h = run ? (act_h ^ invert) : invert;
        next_out_l = run ? (act_l ^ invert) : invert;
    end

    // State registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filt <= 2'h0;
            age[0] <= 8'h00;
            age[1] <= 8'h00;
            db_cnt <= 8'h00;
            out_h <= 1'b0;
            out_l <= 1'b0;
        end else begin
            filt <= next_filt;
            age[0] <= next_age[0];
            age[1] <= next_age[1];
            db_cnt <= next_db_cnt;
            out_h <= next_out_h;
            out_l <= next_out_l;
        end
    end
endmodule
`default_nettype wire

// ### testbench/mpwm_assertions.sv
// Purpose: Port checker for the motor PWM block
// Assumes: Writes land at the edge that samples pready
// Notes: Shadows follow completed APB writes
`timescale 1ns/1ns
`default_nettype none
module mpwm_assertions
    import mpwm_pkg::*;
#(
    parameter int NPAIR = 3 // Pairs
) (
    input wire logic clk, // Clock
    input wire logic resetn, // Reset
    input wire logic [15:0] paddr, // Address
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic debug_mode, // Debug
    input wire logic aux_fault, // Fault 1
    input wire logic comparator_out, // Comparator
    input wire logic fault_pin, // Fault pin
    input wire logic [NPAIR-1:0] pwm_out_h, // High pins
    input wire logic [NPAIR-1:0] pwm_out_l // Low pins
);
    logic wr, en;
    logic [7:0] c1, fm;
    logic [16:0] st, next_st;
    logic [11:0] idx;
    logic [NPAIR-1:0] off;
    // ==========================
    // Shadow of enable, control and mask
    assign idx = paddr[13:2];
    assign wr = psel && penable && pready && pwrite && !pslverr;
    assign {en, c1, fm} = st;
    assign off = c1[INV_LSB +: NPAIR];
    always_comb begin
        next_st = st;
        if (wr && idx == CTL0_IDX)
            next_st[16] = pwdata[EN_BIT];
        if (wr && idx == CTL1_IDX)
            next_st[15:8] = {pwdata[7:6], en ? c1[INDEP_BIT] : pwdata[5], pwdata[4:0]};
        if (wr && !en && idx == FM_IDX)
            next_st[7:0] = pwdata[7:0] & FM_WMASK;
    end
    // Shadow register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            st <= {1'b0, CTL1_RST, FM_RST};
        else
            st <= next_st;
    end
    // ==========================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_held(src, msk);
        (en && src && !msk && !wr)[*4];
    endsequence
    property p_off(src, msk);
        s_held(src, msk) |-> {pwm_out_h, pwm_out_l} == {off, off};
    endproperty
    property p_read(ix, val);
        pready && !pwrite && !pslverr && idx == ix |-> prdata == {24'h0, val};
    endproperty
    AST_APB_READY: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_DEBUG_OFF: assert property (p_off(debug_mode, fm[FM_DBG_BIT]))
        else $error("debug fault left pins on");
    AST_AUX_OFF: assert property (p_off(aux_fault, fm[FM_AUX_BIT]))
        else $error("aux fault left pins on");
    AST_CMP_OFF: assert property (p_off(comparator_out, fm[FM_CMP_BIT]))
        else $error("comparator fault left pins on");
    AST_PIN_OFF: assert property (p_off(fault_pin, fm[FM_PIN_BIT]))
        else $error("pin fault left pins on");
    AST_DISABLED_OFF: assert property ((!en && !wr)[*4] |-> {pwm_out_h, pwm_out_l} == {off, off})
        else $error("pins on while disabled");
    AST_CTL1_READ: assert property (p_read(CTL1_IDX, c1))
        else $error("control read wrong");
    AST_MASK_READ: assert property (p_read(FM_IDX, fm))
        else $error("mask read wrong");
endmodule
bind mpwm_top mpwm_assertions #(.NPAIR(NPAIR)) i_chk (.clk(clk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_mode(debug_mode), .aux_fault(aux_fault),
    .comparator_out(comparator_out), .fault_pin(fault_pin), .pwm_out_h(pwm_out_h),
    .pwm_out_l(pwm_out_l));
`default_nettype wire

// ### testbench/mpwm_gate_model.sv
// Purpose: Gate driver stand-in on the output pins
// Assumes: Gates active high while watched
// Notes: Latches any high and low side overlap
`timescale 1ns/1ns
`default_nettype none
module mpwm_gate_model
    import mpwm_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic resetn, // Reset
    input wire logic watch, // Pair mode, normal polarity
    input wire logic [2:0] gate_h, // High gates
    input wire logic [2:0] gate_l, // Low gates
    output logic shoot // Overlap seen
);
    logic next_shoot;
    logic [2:0] prev_h, prev_l;
    always_comb begin
        next_shoot = shoot || (watch && |((gate_h | prev_h) & (gate_l | prev_l)));
    end
    // Sticky flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shoot <= 1'b0;
            {prev_h, prev_l} <= 6'h00;
        end else begin
            shoot <= next_shoot;
            {prev_h, prev_l} <= {gate_h, gate_l};
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Register, fault and reload bench for the motor PWM block
// Assumes: Access phase answers in one cycle
// Notes: External count clock stays low
`timescale 1ns/1ns
`default_nettype none
module tb
    import mpwm_pkg::*;
;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, watch = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0] src = 4'h0;
    logic [2:0] ph, pl;
    logic pready, pslverr, irq, shoot, e;
    int fails = 0, samples_checked = 0, c;
    mpwm_top i_dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_mode(src[3]), .aux_fault(src[2]), .comparator_out(src[1]), .fault_pin(src[0]),
        .external_count_clock(1'b0), .pwm_out_h(ph), .pwm_out_l(pl), .irq(irq));
    mpwm_gate_model i_gate (.clk(clk), .resetn(resetn), .watch(watch), .gate_h(ph), .gate_l(pl),
        .shoot(shoot));
    // ==========================
    // Clock and watchdog
    initial forever #2 clk = ~clk;
    initial begin
        #300000;
        fails++;
        stop_test();
    end
    // ==========================
    // Bus and compare tasks
    task automatic apb(input logic w, input logic [11:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, ix, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            fails++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic wr(input logic [11:0] ix, input logic [7:0] d);
        apb(1'b1, ix, d);
    endtask
    task automatic rd(input logic [11:0] ix, input logic [7:0] x);
        apb(1'b0, ix, 8'h00);
        chk("register", {24'h0, x}, r);
    endtask
    // Clocks between two reload flags
    task automatic gap();
        wr(IRQ_STAT_IDX, 8'h01);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (irq !== 1'b1 && c < 3000);
        wr(IRQ_STAT_IDX, 8'h01);
        c = 3;
        do begin
            @(posedge clk);
            c++;
        end while (irq !== 1'b1 && c < 3000);
    endtask
    task automatic stop_test();
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================
    // Test sequence
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(CTL1_IDX, 8'h00);
        rd(DB_IDX, 8'h01);
        rd(MPF_IDX, 8'h00);
        apb(1'b0, 12'h000, 8'h00);
        chk("error", 32'h1, {31'h0, e});
        wr(CTL1_IDX, 8'hff);
        rd(CTL1_IDX, 8'hff);
        wr(CTL1_IDX, 8'h14);
        rd(CTL1_IDX, 8'h14);
        chk("pins", {26'h0, ph, pl}, 32'h2d);
        wr(PER_IDX, 8'h07);
        for (int i = 0; i < 6; i++)
            wr(DUTY0_IDX + 12'(i), 8'h04);
        wr(DB_IDX, 8'h02);
        wr(FM_IDX, 8'hff);
        rd(FM_IDX, 8'h27);
        wr(IRQ_MASK_IDX, 8'h02);
        wr(CTL0_IDX, 8'h03);
        for (int i = 0; i < 4; i++) begin
            src <= 4'(1 << i);
            repeat (4) @(posedge clk);
            chk("masked irq", 32'h0, {31'h0, irq});
            src <= 4'h0;
            @(posedge clk);
        end
        wr(DB_IDX, 8'haa);
        rd(DB_IDX, 8'h02);
        wr(FM_IDX, 8'h00);
        rd(FM_IDX, 8'h27);
        wr(CTL1_IDX, 8'h34);
        rd(CTL1_IDX, 8'h14);
        wr(CTL0_IDX, 8'h00);
        wr(FM_IDX, 8'h00);
        wr(CTL0_IDX, 8'h01);
        for (int i = 0; i < 4; i++) begin
            src <= 4'(1 << i);
            repeat (4) @(posedge clk);
            chk("pins", {26'h0, ph, pl}, 32'h2d);
            chk("fault irq", 32'h1, {31'h0, irq});
            src <= 4'h0;
            wr(CTL0_IDX, 8'h00);
            wr(CTL0_IDX, 8'h01);
            wr(IRQ_STAT_IDX, 8'h02);
            @(posedge clk);
            chk("cleared irq", 32'h0, {31'h0, irq});
        end
        wr(IRQ_MASK_IDX, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(CTL1_IDX, {2'(k), 4'h0, 2'(k)});
            wr(CTL0_IDX, 8'h03);
            watch <= 1'b1;
            gap();
            gap();
            chk("reload gap", 32'(8 << (2 * k)), c);
        end
        chk("overlap", 32'h0, {31'h0, shoot});
        stop_test();
    end
endmodule
`default_nettype wire
